// *** spms_pkg.sv ***
// constants, register map and types of the serial master/slave port
package spms_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam int          ADDR_W       = 12;
   localparam logic [11:0] ADDR_DATA    = 12'hf60;
   localparam logic [11:0] ADDR_CTRL    = 12'hf64;
   localparam logic [11:0] ADDR_STAT    = 12'hf68;
   localparam logic [11:0] ADDR_MODE    = 12'hf6c;
   localparam logic [11:0] ADDR_RATE_HI = 12'hf70;
   localparam logic [11:0] ADDR_RATE_LO = 12'hf74;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_EN     = 0;
   localparam int CTRL_MASTER = 1;
   localparam int CTRL_PHASE  = 2;
   localparam int CTRL_CPOL   = 3;
   localparam int CTRL_TMR_EN = 4;
   localparam int CTRL_SSOUT  = 5;
   localparam int CTRL_W      = 6;

   // ----------------------------------------------------------------
   // status register fields
   // ----------------------------------------------------------------
   localparam int STAT_DONE = 0;
   localparam int STAT_COLL = 1;
   localparam int STAT_MODF = 2;
   localparam int STAT_TMR  = 3;
   localparam int STAT_BUSY = 4;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int                 RATE_W     = 16;
   localparam int                 LEN_W      = 3;
   localparam logic [CTRL_W-1:0]  CTRL_RESET = 6'h00;
   localparam logic [LEN_W-1:0]   MODE_RESET = 3'h0;
   localparam logic [RATE_W-1:0]  RATE_RESET = 16'hffff;
   localparam logic [3:0]         FULL_CHAR  = 4'h8;

   typedef enum logic {MST_IDLE, MST_SHIFT} spms_mst_state_t;

   // bits per character; a zero length field means a full byte
   function automatic logic [3:0] spms_char_bits(input logic [LEN_W-1:0] len);
      spms_char_bits = (len == 3'h0) ? FULL_CHAR : {1'b0, len};
   endfunction : spms_char_bits

endpackage : spms_pkg

// *** spms_port.sv ***
// serial master/slave port with APB register access
//
// Function
// - full-duplex four-wire synchronous character channel
// - eight clock cycles exchange one byte
// - shift on one edge, sample opposite
// - select may stay low or rise between characters
// - sole master: select pin input or output
// - select input low while master sets mode fault
// - polarity sets clock idle level only
// - phase 0 edge and idle table
// - phase 1 edge and idle table
// - master presents bit half cycle early
// - timer enable with port disabled runs rate timer with interrupt
// - data read returns shift register
// - master write starts a character
// - slave write preloads shift register
// - write while busy ignored, sets write collision
// - short characters: send MSBs, receive LSBs
// - master drives clock, slave receives it
// - data pin directions follow role
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module spms_port (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial clock pin
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oen,
   // master-out data pin
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oen,
   // master-in data pin
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oen,
   // slave select pin, active low
   input  wire logic        ss_n_i,
   output logic             ss_n_o,
   output logic             ss_n_oen,
   // rate timer request
   output logic             rate_timer_irq
);

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic [spms_pkg::CTRL_W-1:0] ctrl_reg;
   logic [spms_pkg::LEN_W-1:0]  char_length_field;
   logic [spms_pkg::RATE_W-1:0] rate_reg;
   logic [7:0]                  serial_shift_data;
   logic                        cap_reg;
   logic [4:0]                  edge_cnt_reg;
   logic                        sck_reg;
   logic                        done_reg;
   logic                        write_collision_flag;
   logic                        modf_reg;
   logic                        tmr_reg;
   spms_pkg::spms_mst_state_t   mst_state_reg;
   logic [3:0]                  sync1_reg;
   logic [3:0]                  sync2_reg;
   logic                        sck_prev_reg;

   spms_rate_if rif ();

   spms_rate_gen #(.W(spms_pkg::RATE_W)) u_rate (
      .pclk    (pclk),
      .presetn (presetn),
      .rif     (rif.gen)
   );

   // ----------------------------------------------------------------
   // decoded controls
   // ----------------------------------------------------------------
   logic       serial_port_enable_bit;
   logic       is_master;
   logic       phase;
   logic       clock_idle_level_select;
   logic       rate_timer_irq_enable;
   logic       ss_as_output;
   logic       sck_s;
   logic       mosi_s;
   logic       miso_s;
   logic       ss_n_s;
   logic       slave_sel;
   logic       busy;
   logic       lead;
   logic       trail;
   logic       last;
   logic       rx_bit;
   logic       apb_wr;
   logic       wr_data;
   logic       start;
   logic       modf_set;
   logic [4:0] last_edge;

   assign serial_port_enable_bit  = ctrl_reg[spms_pkg::CTRL_EN];
   assign is_master               = ctrl_reg[spms_pkg::CTRL_MASTER];
   assign phase                   = ctrl_reg[spms_pkg::CTRL_PHASE];
   assign clock_idle_level_select = ctrl_reg[spms_pkg::CTRL_CPOL];
   assign rate_timer_irq_enable   = ctrl_reg[spms_pkg::CTRL_TMR_EN];
   assign ss_as_output            = ctrl_reg[spms_pkg::CTRL_SSOUT];

   assign {sck_s, mosi_s, miso_s, ss_n_s} = sync2_reg;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg    <= 4'hf;
         sync2_reg    <= 4'hf;
         sck_prev_reg <= 1'b1;
      end else begin
         sync1_reg    <= {sck_i, mosi_i, miso_i, ss_n_i};
         sync2_reg    <= sync1_reg;
         sck_prev_reg <= sync2_reg[3];
      end
   end

   // ----------------------------------------------------------------
   // edge generation for both roles
   // ----------------------------------------------------------------
   assign slave_sel = serial_port_enable_bit && !is_master && !ss_n_s;
   assign busy      = (mst_state_reg == spms_pkg::MST_SHIFT) || (edge_cnt_reg != 5'h00);
   assign last_edge = 5'({spms_pkg::spms_char_bits(char_length_field), 1'b0} - 5'h01);
   assign rx_bit    = is_master ? miso_s : mosi_s;

   // leading edge leaves the idle level, trailing edge returns to it
   always_comb begin
      lead  = 1'b0;
      trail = 1'b0;
      if (mst_state_reg == spms_pkg::MST_SHIFT) begin
         lead  = rif.tick && (sck_reg == clock_idle_level_select);
         trail = rif.tick && (sck_reg != clock_idle_level_select);
      end else if (slave_sel && (sck_s != sck_prev_reg)) begin
         lead  = (sck_prev_reg == clock_idle_level_select);
         trail = (sck_prev_reg != clock_idle_level_select);
      end
   end

   assign last     = trail && (edge_cnt_reg == last_edge);
   assign apb_wr   = psel && penable && pwrite;
   assign wr_data  = apb_wr && (paddr == spms_pkg::ADDR_DATA);
   assign start    = wr_data && !busy && serial_port_enable_bit && is_master;
   assign modf_set = serial_port_enable_bit && is_master && !ss_as_output
                     && !ss_n_s;

   // ----------------------------------------------------------------
   // edge counter
   // ----------------------------------------------------------------
   // select rising mid-character throws the partial character away
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_cnt_reg <= 5'h00;
      end else if (!serial_port_enable_bit || modf_set
                   || (!is_master && ss_n_s)) begin
         edge_cnt_reg <= 5'h00;
      end else if (lead || trail) begin
         edge_cnt_reg <= last ? 5'h00 : edge_cnt_reg + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // master sequencer and serial clock
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mst_state_reg <= spms_pkg::MST_IDLE;
      end else begin
         case (mst_state_reg)
            spms_pkg::MST_IDLE: begin
               if (start) begin
                  mst_state_reg <= spms_pkg::MST_SHIFT;
               end
            end
            spms_pkg::MST_SHIFT: begin
               if (last || modf_set || !serial_port_enable_bit || !is_master) begin
                  mst_state_reg <= spms_pkg::MST_IDLE;
               end
            end
            default: begin
               mst_state_reg <= spms_pkg::MST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_reg <= 1'b0;
      end else if (mst_state_reg != spms_pkg::MST_SHIFT) begin
         sck_reg <= clock_idle_level_select;
      end else if (rif.tick) begin
         sck_reg <= ~sck_reg;
      end
   end

   // generator serves the clock while shifting, the timer function while the port is disabled
   assign rif.run    = (mst_state_reg == spms_pkg::MST_SHIFT)
                       || (!serial_port_enable_bit && rate_timer_irq_enable);
   assign rif.reload = rate_reg;

   // ----------------------------------------------------------------
   // shift register
   // ----------------------------------------------------------------
   // the outgoing bit is always bit 7, so short characters go out from
   // the top and incoming bits pile up from bit 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_shift_data <= 8'h00;
         cap_reg           <= 1'b0;
      end else if (wr_data && !busy) begin
         serial_shift_data <= pwdata[7:0];
      end else if (lead) begin
         if (!phase) begin
            cap_reg <= rx_bit;
         end else if (edge_cnt_reg != 5'h00) begin
            serial_shift_data <= {serial_shift_data[6:0], cap_reg};
         end
      end else if (trail) begin
         if (!phase) begin
            serial_shift_data <= {serial_shift_data[6:0], cap_reg};
         end else begin
            cap_reg <= rx_bit;
            if (last) begin
               serial_shift_data <= {serial_shift_data[6:0], rx_bit};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers written by software
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg          <= spms_pkg::CTRL_RESET;
         char_length_field <= spms_pkg::MODE_RESET;
         rate_reg          <= spms_pkg::RATE_RESET;
      end else if (apb_wr) begin
         if (paddr == spms_pkg::ADDR_CTRL) begin
            ctrl_reg <= pwdata[spms_pkg::CTRL_W-1:0];
         end else if (paddr == spms_pkg::ADDR_MODE) begin
            char_length_field <= pwdata[spms_pkg::LEN_W-1:0];
         end else if (paddr == spms_pkg::ADDR_RATE_HI) begin
            rate_reg[15:8] <= pwdata[7:0];
         end else if (paddr == spms_pkg::ADDR_RATE_LO) begin
            rate_reg[7:0] <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky status flags, write one to clear, a new event wins
   // ----------------------------------------------------------------
   logic [4:0] clr;
   assign clr = (apb_wr && (paddr == spms_pkg::ADDR_STAT)) ? pwdata[4:0] : 5'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg             <= 1'b0;
         write_collision_flag <= 1'b0;
         modf_reg             <= 1'b0;
         tmr_reg              <= 1'b0;
      end else begin
         if (last) begin
            done_reg <= 1'b1;
         end else if (clr[spms_pkg::STAT_DONE]) begin
            done_reg <= 1'b0;
         end
         if (wr_data && busy) begin
            write_collision_flag <= 1'b1;
         end else if (clr[spms_pkg::STAT_COLL]) begin
            write_collision_flag <= 1'b0;
         end
         if (modf_set) begin
            modf_reg <= 1'b1;
         end else if (clr[spms_pkg::STAT_MODF]) begin
            modf_reg <= 1'b0;
         end
         if (rif.tick && !serial_port_enable_bit && rate_timer_irq_enable) begin
            tmr_reg <= 1'b1;
         end else if (clr[spms_pkg::STAT_TMR]) begin
            tmr_reg <= 1'b0;
         end
      end
   end

   assign rate_timer_irq = tmr_reg && rate_timer_irq_enable;

   // ----------------------------------------------------------------
   // apb read path: captured in the setup cycle, zero wait states
   // ----------------------------------------------------------------
   logic [31:0] rd_val;
   logic        addr_ok;

   always_comb begin
      rd_val  = 32'h0000_0000;
      addr_ok = 1'b1;
      if (paddr == spms_pkg::ADDR_DATA) begin
         rd_val[7:0] = serial_shift_data;
      end else if (paddr == spms_pkg::ADDR_CTRL) begin
         rd_val[spms_pkg::CTRL_W-1:0] = ctrl_reg;
      end else if (paddr == spms_pkg::ADDR_STAT) begin
         rd_val[4:0] = {busy, tmr_reg, modf_reg, write_collision_flag, done_reg};
      end else if (paddr == spms_pkg::ADDR_MODE) begin
         rd_val[spms_pkg::LEN_W-1:0] = char_length_field;
      end else if (paddr == spms_pkg::ADDR_RATE_HI) begin
         rd_val[7:0] = rate_reg[15:8];
      end else if (paddr == spms_pkg::ADDR_RATE_LO) begin
         rd_val[7:0] = rate_reg[7:0];
      end else begin
         addr_ok = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_val;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // ----------------------------------------------------------------
   // pin drive, enables low while driving
   // ----------------------------------------------------------------
   assign sck_o    = sck_reg;
   assign sck_oen  = !(serial_port_enable_bit && is_master);
   assign mosi_o   = serial_shift_data[7];
   assign mosi_oen = !(serial_port_enable_bit && is_master);
   assign miso_o   = serial_shift_data[7];
   assign miso_oen = !slave_sel;
   assign ss_n_o   = (mst_state_reg != spms_pkg::MST_SHIFT);
   assign ss_n_oen = !(serial_port_enable_bit && is_master && ss_as_output);

endmodule : spms_port

// *** spms_port_asserts.sv ***
// port assertions for the serial master/slave port
`timescale 1ns/1ns
module spms_port_asserts (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins
   input wire logic        sck_o,
   input wire logic        sck_oen,
   input wire logic        mosi_oen,
   input wire logic        miso_oen,
   input wire logic        ss_n_o,
   input wire logic        ss_n_oen,
   input wire logic        rate_timer_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic hit;
   assign acc = psel && penable;
   assign hit = paddr >= spms_pkg::ADDR_DATA && paddr <= spms_pkg::ADDR_RATE_LO
                && paddr[1:0] == 2'h0;

   a_unmapped_err: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && hit |-> !pslverr)
      else $error("mapped access refused");
   a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_zero_wait: assert property (psel && !penable |=> pready)
      else $error("access phase not answered at once");
   a_pin_roles: assert property (mosi_oen == sck_oen)
      else $error("clock and data out pins disagree on role");
   a_slave_miso: assert property (!miso_oen |-> sck_oen && mosi_oen)
      else $error("miso driven while master pins driven");
   a_ss_out_master: assert property (!ss_n_oen |-> !sck_oen)
      else $error("select driven outside master role");
   a_frame_hold: assert property ($fell(ss_n_o) && !ss_n_oen |-> !ss_n_o [*3])
      else $error("select released too early");
   a_frame_edge: assert property ($fell(ss_n_o) && !sck_oen |-> $stable(sck_o))
      else $error("clock moved as select fell");
   a_sck_quiet: assert property (!sck_oen && ss_n_o && $past(ss_n_o) && !$past(psel)
      && !$past(psel, 2) && !$past(psel, 3) |-> $stable(sck_o))
      else $error("serial clock moved outside a character");

   c_frame: cover property ($fell(ss_n_o));
   c_refused: cover property (acc && pslverr);
   c_timer: cover property ($rose(rate_timer_irq));
endmodule : spms_port_asserts

// *** spms_rate_gen.sv ***
// reloading down-counter that paces the serial clock or acts as a timer
`timescale 1ns/1ns
module spms_rate_gen #(
   parameter int W = spms_pkg::RATE_W
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // control and tick
   spms_rate_if.gen  rif
);

   logic [W-1:0] cnt_reg;

   if (W < 2 || W > spms_pkg::RATE_W) begin : g_bad_width
      $error("spms_rate_gen: unsupported counter width");
   end

   // ----------------------------------------------------------------
   // counter: a reload of zero behaves as one
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg  <= '0;
         rif.tick <= 1'b0;
      end else if (!rif.run) begin
         cnt_reg  <= rif.reload[W-1:0];
         rif.tick <= 1'b0;
      end else if (cnt_reg <= W'(1)) begin
         cnt_reg  <= rif.reload[W-1:0];
         rif.tick <= 1'b1;
      end else begin
         cnt_reg  <= cnt_reg - W'(1);
         rif.tick <= 1'b0;
      end
   end

endmodule : spms_rate_gen

// *** spms_rate_if.sv ***
// bundle between the port and its bit-rate generator
`timescale 1ns/1ns
interface spms_rate_if;
   logic                        run;
   logic [spms_pkg::RATE_W-1:0] reload;
   logic                        tick;

   modport gen  (input run, input reload, output tick);
   modport user (output run, output reload, input tick);
endinterface : spms_rate_if

// *** spms_slave_model.sv ***
// behavioural external slave on the serial link
`timescale 1ns/1ns
module spms_slave_model (
   // link
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       ss_n,
   // format and data
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte,
   output int              edge_cnt
);
   logic [7:0] shreg = 8'h00;
   int         n_shift = 0;
   wire        ss_dly;
   wire        mosi_dly;
   // hold time: the master may move data and select in the step of its last edge
   assign #1 ss_dly   = ss_n;
   assign #1 mosi_dly = mosi;
   initial begin
      miso = 1'b0;
      rx_byte = 8'h00;
      edge_cnt = 0;
   end
   // phase 1 shows junk until the first leading edge
   always @(negedge ss_n) begin
      shreg = tx_byte;
      rx_byte = 8'h00;
      edge_cnt = 0;
      n_shift = 0;
      miso = cpha ? ~tx_byte[7] : tx_byte[7];
   end
   always @(sck) begin
      if (!ss_dly) begin
         edge_cnt++;
         if ((sck != cpol) ^ cpha) begin
            rx_byte = {rx_byte[6:0], mosi_dly};
         end else begin
            if (!(cpha && n_shift == 0)) shreg = {shreg[6:0], 1'b0};
            n_shift++;
            miso = shreg[7];
         end
      end
   end
   // released line does not keep its last value
   always @(posedge ss_n) miso = ~miso;
endmodule : spms_slave_model

// *** tb_spi_master_slave_port.sv ***
// self-checking bench for the serial master/slave port
`timescale 1ns/1ns
module tb_spi_master_slave_port;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata, seed = 32'h5fda9923;
   logic        pready, pslverr, rerr, irq, s_miso;
   logic        sck_o, sck_oen, mosi_o, mosi_oen, miso_o, miso_oen, ss_n_o, ss_n_oen;
   logic        sck_w, mosi_w, miso_w, ss_w, m_cpol = 1'b0, m_cpha = 1'b0, ss_drv = 1'b1;
   logic [7:0]  s_tx = 8'h00, s_rx, d, s;
   int          s_edges, n, n_mismatch = 0, compares = 0;
   assign sck_w  = sck_oen ? m_cpol : sck_o;
   assign mosi_w = mosi_oen ? ~mosi_o : mosi_o;
   assign miso_w = miso_oen ? s_miso : miso_o;
   assign ss_w   = ss_n_oen ? ss_drv : ss_n_o;
   always #50 pclk = ~pclk;

   spms_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oen(sck_oen), .mosi_i(mosi_w),
      .mosi_o(mosi_o), .mosi_oen(mosi_oen), .miso_i(miso_w), .miso_o(miso_o),
      .miso_oen(miso_oen), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oen(ss_n_oen),
      .rate_timer_irq(irq));
   spms_slave_model peer_u (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .cpol(m_cpol),
      .cpha(m_cpha), .tx_byte(s_tx), .miso(s_miso), .rx_byte(s_rx), .edge_cnt(s_edges));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // short characters leave the old low bits moved up
   function automatic logic [7:0] exp_data(input logic [7:0] dv, input logic [7:0] sv, int nb);
      return (dv << nb) | (sv >> (8 - nb));
   endfunction : exp_data

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, spms_pkg::ADDR_RATE_HI, 32'h0);
      chk("rate_hi reset", 32'hff, rdata);
      apb(1'b0, 12'hffc, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rerr});
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         d = seed[7:0];
         s = seed[15:8];
         n = (i == 0) ? 8 : (i == 1) ? 1 : int'(seed[18:16]) + 1;
         m_cpol <= i[0];
         m_cpha <= i[1];
         s_tx <= s;
         apb(1'b1, spms_pkg::ADDR_CTRL, 32'h0);
         apb(1'b1, spms_pkg::ADDR_RATE_HI, 32'h0);
         apb(1'b1, spms_pkg::ADDR_RATE_LO, 32'h4);
         apb(1'b1, spms_pkg::ADDR_MODE, 32'(n % 8));
         apb(1'b1, spms_pkg::ADDR_CTRL, 32'h23 | {28'h0, i[0], i[1], 2'b00});
         apb(1'b1, spms_pkg::ADDR_DATA, {24'h0, d});
         apb(1'b1, spms_pkg::ADDR_DATA, {24'h0, ~d});
         do apb(1'b0, spms_pkg::ADDR_STAT, 32'h0); while (rdata[spms_pkg::STAT_BUSY] !== 1'b0);
         chk("status", 32'h3, rdata & 32'h7);
         apb(1'b0, spms_pkg::ADDR_DATA, 32'h0);
         chk("data", {24'h0, exp_data(d, s, n)}, rdata);
         chk("peer rx", 32'(d >> (8 - n)), {24'h0, s_rx});
         chk("sck edges", 32'(2 * n), 32'(s_edges));
         chk("sck idle", {31'h0, i[0]}, {31'h0, sck_o});
         apb(1'b1, spms_pkg::ADDR_STAT, 32'h7);
      end
      m_cpol <= 1'b0;
      apb(1'b1, spms_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, spms_pkg::ADDR_CTRL, 32'h10);
      repeat (20) @(posedge pclk);
      chk("timer irq", 32'h1, {31'h0, irq});
      apb(1'b1, spms_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, spms_pkg::ADDR_STAT, 32'hf);
      ss_drv <= 1'b0;
      apb(1'b1, spms_pkg::ADDR_CTRL, 32'h3);
      apb(1'b1, spms_pkg::ADDR_DATA, 32'h5a);
      apb(1'b0, spms_pkg::ADDR_STAT, 32'h0);
      chk("mode fault", 32'h4, rdata & 32'h4);
      apb(1'b1, spms_pkg::ADDR_CTRL, 32'h1);
      apb(1'b1, spms_pkg::ADDR_DATA, {24'h0, d});
      apb(1'b0, spms_pkg::ADDR_DATA, 32'h0);
      chk("slave preload", {24'h0, d}, rdata);
      chk("miso pin", {31'h0, d[7]}, {30'h0, miso_oen, miso_o});
      ss_drv <= 1'b1;
      print_verdict();
   end
   // run is under a thousand cycles; twenty thousand means a hang
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
endmodule : tb_spi_master_slave_port

bind spms_port spms_port_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sck_o(sck_o), .sck_oen(sck_oen), .mosi_oen(mosi_oen),
   .miso_oen(miso_oen), .ss_n_o(ss_n_o), .ss_n_oen(ss_n_oen),
   .rate_timer_irq(rate_timer_irq));
